// [src/sacc_top.sv]
// Control of a 10-bit successive-approximation converter with 8-bit comparator mode.
// Assumes one CPU instruction per valid command and one machine cycle per clock.
`default_nettype none
module sacc_top
    import sacc_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire sacc_cmd_t cmd_in,
    input wire logic irq_enable_in,
    input wire logic irq_taken_in,
    input wire logic dac_below_input_in,
    output sacc_rsp_t rsp_out,
    output logic [9:0] dac_code_out,
    output logic [2:0] channel_select_bits_out,
    output logic analog_on_out,
    output logic conv_done_flag_out,
    output logic irq_req_out
);
    sacc_state_t st_ff;
    sacc_state_t nxt_st;
    logic [9:0] step_result;
    logic step_last;
    logic is_cmd;
    logic chan_ok;

    sacc_sar_step u_step (
        .result_in(st_ff.result),
        .bidx_in(st_ff.bidx),
        .keep_in(st_ff.cmp_stable),
        .result_out(step_result),
        .last_out(step_last)
    );

    always_comb begin
        is_cmd = cmd_in.valid;
        chan_ok = (cmd_in.acc_a[1:0] == 2'h0) || (cmd_in.acc_a[1:0] == 2'h1);
        nxt_st = st_ff;
        nxt_st.rsp = '0;
        nxt_st.irq = 1'b0;

        // Three-stage capture of the analog comparator, accepted when stages two and three agree.
        nxt_st.sync[0] = dac_below_input_in;
        nxt_st.sync[1] = st_ff.sync[0];
        nxt_st.sync[2] = st_ff.sync[1];
        if (st_ff.sync[1] == st_ff.sync[2]) begin
            nxt_st.cmp_stable = st_ff.sync[2];
        end

        // Flag clears come first so that a completion in the same cycle wins.
        if (irq_taken_in) begin
            nxt_st.done = 1'b0;
        end

        if (is_cmd) begin
            unique case (cmd_in.op)
                SACC_OP_NOP: begin
                end
                SACC_OP_START: begin
                    if (st_ff.phase == SACC_IDLE) begin
                        nxt_st.mode_cmp = st_ff.ctrl[`SACC_MODE_BIT];
                        nxt_st.chan = st_ff.ctrl[`SACC_CHAN_MSB:0];
                        nxt_st.analog_on = 1'b1;
                        nxt_st.cnt = 6'h00;
                        if (st_ff.ctrl[`SACC_MODE_BIT]) begin
                            nxt_st.phase = SACC_COMPARE;
                            nxt_st.dac = {st_ff.thresh, 2'h0};
                        end else begin
                            nxt_st.phase = SACC_CLEAR;
                            nxt_st.result = `SACC_RESULT_RESET;
                            nxt_st.dac = `SACC_RESULT_RESET;
                        end
                    end
                end
                SACC_OP_SKIP_DONE: begin
                    nxt_st.rsp.valid = 1'b1;
                    if (st_ff.done) begin
                        nxt_st.rsp.skip = 1'b1;
                        nxt_st.done = 1'b0;
                    end
                end
                SACC_OP_LOAD_CMP: begin
                    if (st_ff.ctrl[`SACC_MODE_BIT] && st_ff.phase == SACC_IDLE) begin
                        nxt_st.thresh = {cmd_in.acc_b, cmd_in.acc_a};
                    end
                end
                SACC_OP_READ_LOW: begin
                    nxt_st.rsp.valid = 1'b1;
                    nxt_st.rsp.acc_a = {st_ff.result[1:0], 2'h0};
                end
                SACC_OP_READ_HIGH: begin
                    nxt_st.rsp.valid = 1'b1;
                    nxt_st.rsp.acc_b = st_ff.result[9:6];
                    nxt_st.rsp.acc_a = st_ff.result[5:2];
                end
                SACC_OP_WRITE_CTRL: begin
                    if (st_ff.phase == SACC_IDLE) begin
                        nxt_st.ctrl = cmd_in.acc_a;
                    end
                    if (!chan_ok) begin
                        nxt_st.ctrl[`SACC_CHAN_MSB:0] = st_ff.ctrl[`SACC_CHAN_MSB:0];
                    end
                    if (st_ff.phase != SACC_IDLE) begin
                        nxt_st.ctrl = st_ff.ctrl;
                    end
                end
                SACC_OP_READ_CTRL: begin
                    nxt_st.rsp.valid = 1'b1;
                    nxt_st.rsp.acc_a = st_ff.ctrl;
                end
                SACC_OP_READ_CMP: begin
                    nxt_st.rsp.valid = 1'b1;
                    if (st_ff.ctrl[`SACC_MODE_BIT]) begin
                        nxt_st.rsp.acc_b = st_ff.thresh[7:4];
                        nxt_st.rsp.acc_a = st_ff.thresh[3:0];
                    end
                end
                default: begin
                end
            endcase
        end

        // Sequencing of a running operation; one count per machine cycle.
        unique case (st_ff.phase)
            SACC_IDLE: begin
            end
            SACC_CLEAR: begin
                nxt_st.cnt = st_ff.cnt + 6'h01;
                nxt_st.result = {1'b1, 9'h000};
                nxt_st.dac = {1'b1, 9'h000};
                nxt_st.bidx = `SACC_TOP_BIT;
                nxt_st.step = 3'h0;
                nxt_st.phase = SACC_TRIAL;
            end
            SACC_TRIAL: begin
                nxt_st.cnt = st_ff.cnt + 6'h01;
                if (st_ff.step == `SACC_STEP_LAST) begin
                    nxt_st.step = 3'h0;
                    nxt_st.result = step_result;
                    nxt_st.dac = step_result;
                    if (!step_last) begin
                        nxt_st.bidx = st_ff.bidx - 4'h1;
                    end else begin
                        nxt_st.result = step_result & ~10'h000;
                        nxt_st.dac = step_result;
                    end
                end else begin
                    nxt_st.step = st_ff.step + 3'h1;
                end
                if (st_ff.step == `SACC_STEP_LAST && step_last) begin
                    nxt_st.result = st_ff.cmp_stable ? st_ff.result
                                                     : (st_ff.result & 10'h3FE);
                    nxt_st.dac = nxt_st.result;
                end
                if (st_ff.cnt == `SACC_CONV_CYCLES - 6'h01) begin
                    nxt_st.phase = SACC_IDLE;
                    nxt_st.analog_on = 1'b0;
                    nxt_st.done = 1'b1;
                    nxt_st.irq = irq_enable_in;
                end
            end
            SACC_COMPARE: begin
                nxt_st.cnt = st_ff.cnt + 6'h01;
                if (st_ff.cnt == `SACC_CMP_CYCLES - 6'h01) begin
                    nxt_st.phase = SACC_IDLE;
                    nxt_st.analog_on = 1'b0;
                    if (!st_ff.cmp_stable) begin
                        nxt_st.done = 1'b1;
                        nxt_st.irq = irq_enable_in;
                    end
                end
            end
        endcase
    end

    // Synchronous reset to idle conversion mode with all flags clear.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st_ff <= '0;
            st_ff.ctrl <= `SACC_CTRL_RESET;
            st_ff.result <= `SACC_RESULT_RESET;
            st_ff.thresh <= `SACC_THRESH_RESET;
            st_ff.phase <= SACC_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rsp_out = st_ff.rsp;
    assign dac_code_out = st_ff.dac;
    assign channel_select_bits_out = st_ff.chan;
    assign analog_on_out = st_ff.analog_on;
    assign conv_done_flag_out = st_ff.done;
    assign irq_req_out = st_ff.irq;
endmodule : sacc_top
`default_nettype wire

// [include/sacc_cfg.svh]
// Timing counts, field positions and reset values of the converter control.
// Assumes one machine cycle per clk_in cycle.
`ifndef SACC_CFG_SVH
`define SACC_CFG_SVH
`define SACC_CONV_CYCLES 6'h3E
`define SACC_CMP_CYCLES 6'h08
`define SACC_STEP_LAST 3'h5
`define SACC_MODE_BIT 3
`define SACC_CHAN_MSB 2
`define SACC_CTRL_RESET 4'h0
`define SACC_RESULT_RESET 10'h000
`define SACC_THRESH_RESET 8'h00
`define SACC_TOP_BIT 4'h9
`endif

// [include/sacc_pkg.sv]
// Types shared by the converter control, its checker and its testbench.
// Assumes sacc_cfg.svh is on the include path.
`default_nettype none
`include "sacc_cfg.svh"
package sacc_pkg;
    typedef enum logic [3:0] {
        SACC_OP_NOP,
        SACC_OP_START,
        SACC_OP_SKIP_DONE,
        SACC_OP_LOAD_CMP,
        SACC_OP_READ_LOW,
        SACC_OP_READ_HIGH,
        SACC_OP_WRITE_CTRL,
        SACC_OP_READ_CTRL,
        SACC_OP_READ_CMP
    } sacc_op_t;
    typedef enum logic [1:0] {
        SACC_IDLE,
        SACC_CLEAR,
        SACC_TRIAL,
        SACC_COMPARE
    } sacc_phase_t;
    typedef struct packed {
        logic valid;
        sacc_op_t op;
        logic [3:0] acc_a;
        logic [3:0] acc_b;
    } sacc_cmd_t;
    typedef struct packed {
        logic valid;
        logic skip;
        logic [3:0] acc_a;
        logic [3:0] acc_b;
    } sacc_rsp_t;
    typedef struct packed {
        sacc_phase_t phase;
        logic [3:0] ctrl;
        logic mode_cmp;
        logic [2:0] chan;
        logic analog_on;
        logic [9:0] result;
        logic [7:0] thresh;
        logic [9:0] dac;
        logic [5:0] cnt;
        logic [3:0] bidx;
        logic [2:0] step;
        logic done;
        logic irq;
        sacc_rsp_t rsp;
        logic [2:0] sync;
        logic cmp_stable;
    } sacc_state_t;
endpackage : sacc_pkg
`default_nettype wire

// [src/sacc_sar_step.sv]
// One successive-approximation step on the result word.
// Assumes the caller holds the trial bit index steady while it is used.
`default_nettype none
module sacc_sar_step (
    input wire logic [9:0] result_in,
    input wire logic [3:0] bidx_in,
    input wire logic keep_in,
    output logic [9:0] result_out,
    output logic last_out
);
    logic [9:0] cur_mask;
    logic [9:0] next_mask;
    always_comb begin
        cur_mask = 10'h001 << bidx_in;
        next_mask = cur_mask >> 1;
        result_out = result_in;
        if (!keep_in) begin
            result_out = result_in & ~cur_mask;
        end
        result_out = result_out | next_mask;
        last_out = (bidx_in == 4'h0);
    end
endmodule : sacc_sar_step
`default_nettype wire

// [dv/sacc_afe_model.sv]
// Analog front end model: a comparator between the DAC code and an input level.
// Assumes the level is given in DAC steps and never changes within a trial.
`default_nettype none
module sacc_afe_model (
    input wire logic [9:0] dac_code_in,
    input wire logic [10:0] level_in,
    output logic below_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // High when the DAC voltage is below the input level.
    assign below_out = ({1'b0, dac_code_in} < level_in);
endmodule : sacc_afe_model
`default_nettype wire

// [dv/sacc_top_props.sv]
// Timing checks on the ports of the converter control.
// Assumes binding into sacc_top.
`default_nettype none
module sacc_chk
    import sacc_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire sacc_cmd_t cmd_in,
    input wire logic irq_enable_in,
    input wire logic irq_taken_in,
    input wire logic dac_below_input_in,
    input wire sacc_rsp_t rsp_out,
    input wire logic [9:0] dac_code_out,
    input wire logic [2:0] channel_select_bits_out,
    input wire logic analog_on_out,
    input wire logic conv_done_flag_out,
    input wire logic irq_req_out
);
    logic [6:0] on_cnt_ff;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // Counts the cycles of one running operation.
    always_ff @(posedge clk_in) begin
        on_cnt_ff <= (!rst_n_in || !analog_on_out) ? 7'h00 : on_cnt_ff + 7'h01;
    end
    a_irq_with_flag: assert property (irq_req_out |-> conv_done_flag_out && $fell(analog_on_out))
        else $error("interrupt request without completion");
    a_irq_gated: assert property (irq_req_out |-> $past(irq_enable_in))
        else $error("interrupt request while disabled");
    a_flag_at_end: assert property ($rose(conv_done_flag_out) |-> $fell(analog_on_out))
        else $error("done flag rose outside completion");
    a_op_length: assert property ($fell(analog_on_out) |-> on_cnt_ff == 7'h3E || on_cnt_ff == 7'h08)
        else $error("operation length wrong");
    a_start_runs: assert property (cmd_in.valid && cmd_in.op == SACC_OP_START && !analog_on_out
        |=> analog_on_out)
        else $error("start did not begin an operation");
    a_first_trial: assert property ($rose(analog_on_out) && dac_code_out == 10'h000
        |=> dac_code_out == 10'h200)
        else $error("first trial code wrong");
    a_skip_clears: assert property (cmd_in.valid && cmd_in.op == SACC_OP_SKIP_DONE
        && conv_done_flag_out && !analog_on_out |=> !conv_done_flag_out)
        else $error("skip test left flag set");
    a_taken_clears: assert property (irq_taken_in && !analog_on_out |=> !conv_done_flag_out)
        else $error("interrupt acceptance left flag set");
    a_chan_held: assert property (analog_on_out && $past(analog_on_out)
        |-> $stable(channel_select_bits_out))
        else $error("channel changed while running");
    a_reset_clear: assert property (disable iff (1'b0) !rst_n_in
        |=> !analog_on_out && !conv_done_flag_out && channel_select_bits_out == 3'h0)
        else $error("reset state wrong");
    c_conv: cover property ($fell(analog_on_out) && on_cnt_ff == 7'h3E);
    c_cmp: cover property ($fell(analog_on_out) && on_cnt_ff == 7'h08);
    c_irq: cover property (irq_req_out);
endmodule : sacc_chk
bind sacc_top sacc_chk sacc_chk_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .cmd_in(cmd_in),
    .irq_enable_in(irq_enable_in), .irq_taken_in(irq_taken_in),
    .dac_below_input_in(dac_below_input_in), .rsp_out(rsp_out), .dac_code_out(dac_code_out),
    .channel_select_bits_out(channel_select_bits_out), .analog_on_out(analog_on_out),
    .conv_done_flag_out(conv_done_flag_out), .irq_req_out(irq_req_out));
`default_nettype wire

// [dv/tb_sar_adc_and_comparator_control.sv]
// Testbench of the converter control: command tasks and checked sequences.
// Assumes sacc_afe_model stands in for the analog comparator.
`default_nettype none
module tb_sar_adc_and_comparator_control
    import sacc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in, rst_n_in, irq_enable_in, irq_taken_in, below, analog_on_out, done, irq;
    sacc_cmd_t cmd_in;
    sacc_rsp_t rsp_out;
    logic [9:0] dac_code_out, res, dac0;
    logic [2:0] chan;
    logic [10:0] level;
    logic [8:0] v;
    logic [10:0] lv [4] = '{11'h001, 11'h12C, 11'h400, 11'h2AB};
    int n_fail, n_compared, cycles;
    sacc_top sacc_top_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .cmd_in(cmd_in),
        .irq_enable_in(irq_enable_in), .irq_taken_in(irq_taken_in), .dac_below_input_in(below),
        .rsp_out(rsp_out), .dac_code_out(dac_code_out), .channel_select_bits_out(chan),
        .analog_on_out(analog_on_out), .conv_done_flag_out(done), .irq_req_out(irq));
    sacc_afe_model sacc_afe_model_i (.dac_code_in(dac_code_out), .level_in(level), .below_out(below));
    task automatic end_sim();
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic issue(input sacc_op_t op, input logic [3:0] a, input logic [3:0] b);
        @(posedge clk_in);
        cmd_in <= '{1'b1, op, a, b};
        @(posedge clk_in);
        cmd_in <= '0;
    endtask : issue
    task automatic rd(input sacc_op_t op);
        v = 'x;
        issue(op, 4'h0, 4'h0);
        repeat (3) begin
            #1;
            if (rsp_out.valid === 1'b1) begin
                v = {rsp_out.skip, rsp_out.acc_b, rsp_out.acc_a};
                break;
            end
            @(posedge clk_in);
        end
    endtask : rd
    task automatic run(input logic [10:0] l, input int en, input logic ef);
        int n;
        level = l;
        issue(SACC_OP_START, 4'h0, 4'h0);
        #1;
        dac0 = dac_code_out;
        n = 0;
        do begin
            @(posedge clk_in);
            #1;
            n++;
        end while (analog_on_out && n < 100);
        chk(10'(n), 10'(en));
        chk(10'(done), 10'(ef));
        chk(10'(irq), 10'(ef & irq_enable_in));
    endtask : run
    task automatic skip(input logic e);
        rd(SACC_OP_SKIP_DONE);
        chk(10'(v[8]), 10'(e));
    endtask : skip
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            end_sim();
        end
    end
    initial begin
        {rst_n_in, irq_enable_in, irq_taken_in, level, cmd_in} = '0;
        repeat (10) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd(SACC_OP_READ_CTRL);
        chk({2'h0, v[3:0], done, irq, analog_on_out, 1'b0}, 10'h000);
        issue(SACC_OP_WRITE_CTRL, 4'h4, 4'h0);
        issue(SACC_OP_WRITE_CTRL, 4'h2, 4'h0);
        rd(SACC_OP_READ_CTRL);
        chk(10'(v[3:0]), 10'h004);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_in);
            irq_enable_in <= i[1];
            run(lv[i], 62, 1'b1);
            chk({dac0, 7'h00, chan}, {10'h000, 7'h00, 3'h4});
            rd(SACC_OP_READ_HIGH);
            res[9:2] = v[7:0];
            rd(SACC_OP_READ_LOW);
            res[1:0] = v[3:2];
            chk(10'(v[1:0]), 10'h000);
            chk(res, 10'(lv[i] - 11'h001));
            if (i[0]) begin
                @(posedge clk_in);
                irq_taken_in <= 1'b1;
                @(posedge clk_in);
                irq_taken_in <= 1'b0;
                #1;
                chk(10'(done), 10'h000);
            end else skip(1'b1);
        end
        skip(1'b0);
        issue(SACC_OP_LOAD_CMP, 4'hC, 4'h3);
        issue(SACC_OP_WRITE_CTRL, 4'hD, 4'h0);
        rd(SACC_OP_READ_CMP);
        chk(10'(v[7:0]), 10'h000);
        issue(SACC_OP_LOAD_CMP, 4'hC, 4'h3);
        rd(SACC_OP_READ_CMP);
        chk(10'(v[7:0]), 10'h03C);
        run(11'h064, 8, 1'b1);
        chk({dac0[9:3], chan}, {7'h1E, 3'h5});
        skip(1'b1);
        run(11'h1F4, 8, 1'b0);
        @(posedge clk_in);
        irq_enable_in <= 1'b0;
        issue(SACC_OP_WRITE_CTRL, 4'h1, 4'h0);
        skip(1'b0);
        rd(SACC_OP_READ_CMP);
        chk(10'(v[7:0]), 10'h000);
        issue(SACC_OP_WRITE_CTRL, 4'h8, 4'h0);
        rd(SACC_OP_READ_CMP);
        chk(10'(v[7:0]), 10'h03C);
        end_sim();
    end
endmodule : tb_sar_adc_and_comparator_control
`default_nettype wire
